/* File: logic/isac_avg.sv */
// per-channel sliding average over 1, 4, 8 or 32 samples
// assumes depth is fixed while running and one sample per cycle at most
`timescale 1ns/1ns
module isac_avg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // incoming sample and its depth
  input isac_pkg::isac_sample_t in_smp,
  input wire logic [2:0] depth_log2,
  // mean, one-cycle valid
  output isac_pkg::isac_sample_t out_smp
);
  import isac_pkg::*;

  logic [15:0] mem [NUM_CH][32];
  isac_avg_state_t st;
  isac_avg_state_t next_st;

  always_comb begin
    logic [2:0] ch;
    logic [5:0] depth;
    logic [15:0] oldest;
    logic signed [20:0] nsum;
    ch = in_smp.channel;
    depth = 6'(1) << depth_log2;
    oldest = (st.fill[ch] >= depth) ? mem[ch][st.ptr[ch]] : 16'h0000;
    nsum = $signed(st.sum[ch]) + 21'($signed(in_smp.value)) - 21'($signed(oldest));
    next_st = st;
    next_st.out.valid = 1'b0;
    if (in_smp.valid) begin
      // oldest sample leaves the sum as the new one enters
      next_st.sum[ch] = nsum;
      next_st.ptr[ch] = ({1'b0, st.ptr[ch]} + 6'h01 == depth) ? 5'h00 : st.ptr[ch] + 5'h01;
      if (st.fill[ch] < depth) begin
        next_st.fill[ch] = st.fill[ch] + 6'h01;
      end
      next_st.out.valid = 1'b1;
      next_st.out.channel = ch;
      next_st.out.value = 16'(nsum >>> depth_log2);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (in_smp.valid) begin
      mem[in_smp.channel][st.ptr[in_smp.channel]] <= in_smp.value;
    end
  end

  assign out_smp = st.out;
endmodule : isac_avg

/* File: logic/isac_top.sv */
// scan sequencer, averaging, status code and avalon register slave
// assumes a converter on the same clock and switch pins from outside
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - thermocouple readings in celsius if border switch position 4 on, else fahrenheit.
// - group one depth from border switch positions 5,6; group two from 7,8.
// - switch pair on-on gives 1, off-on 4, on-off 8, off-off 32 samples.
// - each sample enters a stack; the mean over the depth is delivered.
// - a group set to the not-used code is skipped entirely while scanning.
// - normal scan converts channels one to eight in order, then wraps.
// - priority scan order is 1,2,1,3,1,4,1,5,6,1,7,1,8, then repeats.
// - scan option switch position 1 on selects priority scan, off sequential.
// - priority scan is never used when thermocouple ranges are selected.
// - priority scan refreshes channel one about every 3 ms, others 16 ms.
// - fast mode refreshes high-level inputs in 12 ms, thermocouples 260 ms.
// - accurate mode refreshes high-level inputs in 24 ms, thermocouples 285 ms.
// - scan option position 2 off means fast, on means accurate, both groups.
// - scan option positions three and above have no effect.
// - after good start-up the status byte 31:24 of every register except the control register reads C7.
// - a failed start-up shows a different status code naming the failure.
// - run light on while the sequencer works, regardless of conversion validity.
// - group one is channel one up to the border channel; group two follows.
// - each group uses the range its group switch gives; all ones is unused.
module isac_top #(
  parameter int FAST_HL_SLOT = isac_pkg::FAST_HL_SLOT_CYC,
  parameter int FAST_TC_SLOT = isac_pkg::FAST_TC_SLOT_CYC,
  parameter int ACC_HL_SLOT = isac_pkg::ACC_HL_SLOT_CYC,
  parameter int ACC_TC_SLOT = isac_pkg::ACC_TC_SLOT_CYC,
  parameter int PRIO_SLOT = isac_pkg::PRIO_SLOT_CYC,
  parameter int CONV_TIMEOUT = isac_pkg::CONV_TIMEOUT_CYC,
  parameter int INIT_WAIT = isac_pkg::INIT_WAIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // switch pins, bit 0 is position 1, on is high
  input wire logic [7:0] group_range_switch,
  input wire logic [7:0] border_units_average_switch,
  input wire logic [5:0] scan_option_switch,
  // converter
  output isac_pkg::isac_conv_req_t conv_req,
  input isac_pkg::isac_conv_rsp_t conv_rsp,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // indicator
  output logic run_led
);
  import isac_pkg::*;

  typedef struct packed {
    isac_state_t state;
    logic [7:0] grp_s1;
    logic [7:0] grp_s2;
    logic [7:0] bun_s1;
    logic [7:0] bun_s2;
    logic [5:0] scan_s1;
    logic [5:0] scan_s2;
    logic [7:0] sw_grp;
    logic [7:0] sw_bun;
    logic [5:0] sw_scan;
    logic [3:0] pos;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] wdog;
    logic [7:0] status;
    logic run;
    logic scan_en;
    logic ack;
    logic [31:0] rdata;
    isac_conv_req_t req;
    logic [7:0][15:0] data;
  } isac_top_state_t;

  isac_top_state_t st;
  isac_top_state_t next_st;
  isac_sample_t avg_in;
  isac_sample_t avg_out;
  logic [2:0] avg_log2;

  // decoded configuration
  logic [3:0] code1;
  logic [3:0] code2;
  logic [2:0] border;
  logic [7:0] active;
  logic [7:0] is_tc;
  logic prio;
  logic fast;
  logic celsius;

  function automatic logic [2:0] slot_ch(input logic [3:0] pos, input logic pr);
    return pr ? isac_prio_ch(pos) : pos[2:0];
  endfunction : slot_ch

  // next slot whose channel is scanned, wrapping at the order length
  function automatic logic [3:0] next_pos(input logic [3:0] pos, input logic pr, input logic [7:0] act);
    int len;
    logic [3:0] cand;
    logic [3:0] res;
    logic found;
    len = pr ? PRIO_SLOTS : NUM_CH;
    res = pos;
    found = 1'b0;
    for (int i = 1; i <= PRIO_SLOTS; i++) begin
      cand = 4'((int'(pos) + i) % len);
      if (!found && i <= len && act[slot_ch(cand, pr)]) begin
        res = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_pos

  function automatic logic [15:0] to_fahrenheit(input logic [15:0] c);
    logic signed [20:0] t;
    t = 21'($signed(c)) * 21'(F_MUL);
    t = t / 21'(F_DIV);
    return 16'(t + 21'(F_OFS));
  endfunction : to_fahrenheit

  always_comb begin
    code1 = {st.sw_grp[0], st.sw_grp[1], st.sw_grp[2], st.sw_grp[3]};
    code2 = {st.sw_grp[4], st.sw_grp[5], st.sw_grp[6], st.sw_grp[7]};
    border = ~{st.sw_bun[2], st.sw_bun[1], st.sw_bun[0]};
    for (int c = 0; c < NUM_CH; c++) begin
      if (3'(c) <= border) begin
        active[c] = (code1 != RANGE_UNUSED);
        is_tc[c] = isac_is_tc(code1);
      end else begin
        active[c] = (code2 != RANGE_UNUSED);
        is_tc[c] = isac_is_tc(code2);
      end
    end
    prio = st.sw_scan[0] && !(|(active & is_tc));
    fast = !st.sw_scan[1];
    celsius = st.sw_bun[3];
  end

  // averager feed and depth per group
  always_comb begin
    avg_in.valid = (st.state == ST_CONV) && conv_rsp.done;
    avg_in.channel = st.req.channel;
    avg_in.value = conv_rsp.data;
    if (st.req.channel <= border) begin
      avg_log2 = isac_depth_log2(st.sw_bun[4], st.sw_bun[5]);
    end else begin
      avg_log2 = isac_depth_log2(st.sw_bun[6], st.sw_bun[7]);
    end
  end

  isac_avg u_avg (
    .clk(clk),
    .rst_n(rst_n),
    .in_smp(avg_in),
    .depth_log2(avg_log2),
    .out_smp(avg_out)
  );

  always_comb begin
    logic [2:0] ch;
    logic [3:0] idx;
    logic [TMR_W-1:0] slot;
    slot = '0;
    ch = slot_ch(st.pos, prio);
    idx = avs_address[5:2];
    if (prio) begin
      slot = TMR_W'(PRIO_SLOT);
    end else if (is_tc[ch]) begin
      slot = fast ? TMR_W'(FAST_TC_SLOT) : TMR_W'(ACC_TC_SLOT);
    end else begin
      slot = fast ? TMR_W'(FAST_HL_SLOT) : TMR_W'(ACC_HL_SLOT);
    end
    next_st = st;
    next_st.grp_s1 = group_range_switch;
    next_st.grp_s2 = st.grp_s1;
    next_st.bun_s1 = border_units_average_switch;
    next_st.bun_s2 = st.bun_s1;
    next_st.scan_s1 = scan_option_switch;
    next_st.scan_s2 = st.scan_s1;
    next_st.req.start = 1'b0;
    if (st.timer != '0) begin
      next_st.timer = st.timer - TMR_W'(1);
    end
    case (st.state)
      ST_INIT: begin
        if (st.timer == '0) begin
          // switches taken once, held until the next reset
          next_st.sw_grp = st.grp_s2;
          next_st.sw_bun = st.bun_s2;
          next_st.sw_scan = st.scan_s2;
          next_st.timer = TMR_W'(INIT_WAIT);
          next_st.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (conv_rsp.ready) begin
          next_st.status = STAT_NORMAL;
          next_st.run = 1'b1;
          next_st.timer = '0;
          next_st.pos = next_pos(prio ? 4'(PRIO_SLOTS - 1) : 4'(NUM_CH - 1), prio, active);
          next_st.state = ST_WAIT;
        end else if (st.timer == '0) begin
          next_st.status = STAT_DCDC;
          next_st.state = ST_FAIL;
        end
      end
      ST_WAIT: begin
        if (st.timer == '0 && st.scan_en && active[ch]) begin
          next_st.req.start = 1'b1;
          next_st.req.channel = ch;
          next_st.req.tc = is_tc[ch];
          next_st.timer = slot;
          next_st.wdog = '0;
          next_st.pos = next_pos(st.pos, prio, active);
          next_st.state = ST_CONV;
        end else if (!active[ch]) begin
          next_st.pos = next_pos(st.pos, prio, active);
        end
      end
      ST_CONV: begin
        next_st.wdog = st.wdog + TMR_W'(1);
        if (conv_rsp.done) begin
          next_st.state = ST_WAIT;
        end else if (st.wdog == TMR_W'(CONV_TIMEOUT)) begin
          // converter stopped answering
          next_st.status = STAT_WDOG;
          next_st.run = 1'b0;
          next_st.state = ST_FAIL;
        end
      end
      ST_FAIL: begin
        next_st.run = 1'b0;
      end
      default: begin
        next_st.state = ST_FAIL;
      end
    endcase
    if (avg_out.valid) begin
      if (is_tc[avg_out.channel] && !celsius) begin
        next_st.data[avg_out.channel] = to_fahrenheit(avg_out.value);
      end else begin
        next_st.data[avg_out.channel] = avg_out.value;
      end
    end
    // register slave, one wait cycle per access
    next_st.ack = (avs_read || avs_write) && !st.ack;
    if (avs_read && !st.ack) begin
      next_st.rdata = '0;
      if (idx < REG_TC_OPEN) begin
        next_st.rdata[15:0] = st.data[idx[2:0]];
      end else if (idx == REG_SW_GRP) begin
        next_st.rdata[15:0] = {st.sw_grp, st.sw_bun};
      end else if (idx == REG_SW_SCAN) begin
        next_st.rdata[5:0] = st.sw_scan;
      end
      if (idx <= REG_SW_SCAN) begin
        next_st.rdata[STAT_LSB +: 8] = st.status;
      end
      if (idx == REG_CTRL) begin
        next_st.rdata[CTRL_SCAN_EN_BIT] = st.scan_en;
      end
    end
    if (avs_write && st.ack && idx == REG_CTRL) begin
      next_st.scan_en = avs_writedata[CTRL_SCAN_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= ST_INIT;
      st.timer <= SETTLE_CYC;
      st.status <= STAT_DIAG;
      st.scan_en <= CTRL_SCAN_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign conv_req = st.req;
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign run_led = st.run;
endmodule : isac_top

/* File: pkg/isac_pkg.sv */
// shared constants, types and decode helpers of the input scan/average control
// assumes a 25 MHz clock and switch inputs with bit 0 as switch position 1
package isac_pkg;
  localparam int CLK_MHZ = 25;
  localparam int NUM_CH = 8;
  // update periods in microseconds
  localparam int FAST_HL_PERIOD_US = 12000;
  localparam int FAST_TC_PERIOD_US = 260000;
  localparam int ACC_HL_PERIOD_US = 24000;
  localparam int ACC_TC_PERIOD_US = 285000;
  localparam int PRIO_PERIOD_US = 16000;
  localparam int PRIO_SLOTS = 13;
  localparam int CONV_TIMEOUT_US = 2000;
  localparam int INIT_WAIT_US = 1000;
  // slot lengths in cycles, only the priority slot rounds down
  localparam int FAST_HL_SLOT_CYC = FAST_HL_PERIOD_US * CLK_MHZ / NUM_CH;
  localparam int FAST_TC_SLOT_CYC = FAST_TC_PERIOD_US * CLK_MHZ / NUM_CH;
  localparam int ACC_HL_SLOT_CYC = ACC_HL_PERIOD_US * CLK_MHZ / NUM_CH;
  localparam int ACC_TC_SLOT_CYC = ACC_TC_PERIOD_US * CLK_MHZ / NUM_CH;
  localparam int PRIO_SLOT_CYC = PRIO_PERIOD_US * CLK_MHZ / PRIO_SLOTS;
  localparam int CONV_TIMEOUT_CYC = CONV_TIMEOUT_US * CLK_MHZ;
  localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
  localparam logic [19:0] SETTLE_CYC = 20'h00004;
  localparam int TMR_W = 20;
  // status byte, bits 31:24 of every register word below REG_CTRL
  localparam int STAT_LSB = 24;
  localparam logic [7:0] STAT_NORMAL = 8'hC7;
  localparam logic [7:0] STAT_DIAG = 8'h69;
  localparam logic [7:0] STAT_DCDC = 8'h60;
  localparam logic [7:0] STAT_WDOG = 8'h53;
  // register indices, byte offset is four times the index
  localparam logic [3:0] REG_DATA0 = 4'h0;
  localparam logic [3:0] REG_TC_OPEN = 4'h8;
  localparam logic [3:0] REG_TC_UNDER = 4'h9;
  localparam logic [3:0] REG_SW_GRP = 4'hA;
  localparam logic [3:0] REG_SW_SCAN = 4'hB;
  localparam logic [3:0] REG_CTRL = 4'hC;
  localparam int CTRL_SCAN_EN_BIT = 0;
  localparam logic CTRL_SCAN_EN_RESET = 1'b1;
  // range codes, switch positions 1..4 written msb first
  localparam logic [3:0] RANGE_UNUSED = 4'hF;
  // averaging depth as log2
  localparam logic [2:0] LOG2_D1 = 3'h0;
  localparam logic [2:0] LOG2_D4 = 3'h2;
  localparam logic [2:0] LOG2_D8 = 3'h3;
  localparam logic [2:0] LOG2_D32 = 3'h5;
  // fahrenheit from tenths of a degree celsius
  localparam int F_MUL = 9;
  localparam int F_DIV = 5;
  localparam int F_OFS = 320;

  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_CONV = 5'b01000,
    ST_FAIL = 5'b10000
  } isac_state_t;

  typedef struct packed {
    logic start;
    logic [2:0] channel;
    logic tc;
  } isac_conv_req_t;

  typedef struct packed {
    logic ready;
    logic done;
    logic [15:0] data;
  } isac_conv_rsp_t;

  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [15:0] value;
  } isac_sample_t;

  typedef struct packed {
    logic [7:0][4:0] ptr;
    logic [7:0][5:0] fill;
    logic [7:0][20:0] sum;
    isac_sample_t out;
  } isac_avg_state_t;

  function automatic logic isac_is_tc(input logic [3:0] code);
    case (code)
      4'h7, 4'hB, 4'h3, 4'hD, 4'h0, 4'h5, 4'h9, 4'h1, 4'hE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : isac_is_tc

  function automatic logic [2:0] isac_depth_log2(input logic lower, input logic higher);
    case ({lower, higher})
      2'b11: return LOG2_D1;
      2'b01: return LOG2_D4;
      2'b10: return LOG2_D8;
      default: return LOG2_D32;
    endcase
  endfunction : isac_depth_log2

  // channel index for a slot of the channel-one priority order
  function automatic logic [2:0] isac_prio_ch(input logic [3:0] pos);
    case (pos)
      4'h1: return 3'h1;
      4'h3: return 3'h2;
      4'h5: return 3'h3;
      4'h7: return 3'h4;
      4'h8: return 3'h5;
      4'hA: return 3'h6;
      4'hC: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction : isac_prio_ch
endpackage : isac_pkg

/* File: test/isac_checker.sv */
// concurrent checks on the ports of the scan/average control top
// bound to isac_top; switch pins are assumed steady while running
`timescale 1ns/1ns
module isac_checker #(
  parameter int FAST_HL_SLOT = 20,
  parameter int PRIO_SLOT = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // switches
  input wire logic [7:0] group_range_switch,
  input wire logic [7:0] border_units_average_switch,
  input wire logic [5:0] scan_option_switch,
  // converter
  input isac_pkg::isac_conv_req_t conv_req,
  // register bus and indicator
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic run_led
);
  import isac_pkg::*;
  localparam int MIN_SLOT = FAST_HL_SLOT < PRIO_SLOT ? FAST_HL_SLOT : PRIO_SLOT;
  logic [19:0] gap;
  logic seen;
  logic [2:0] last_ch;
  logic [2:0] bord;
  logic prio_hl;
  logic seq8;
  assign bord = ~border_units_average_switch[2:0];
  assign prio_hl = scan_option_switch[0] && group_range_switch == 8'h55;
  assign seq8 = !scan_option_switch[0] && bord == 3'h7 && group_range_switch[3:0] != 4'hF;
  // cycles since the last start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 20'h00000;
      seen <= 1'b0;
      last_ch <= 3'h0;
    end else if (conv_req.start) begin
      gap <= 20'h00001;
      seen <= 1'b1;
      last_ch <= conv_req.channel;
    end else if (gap != 20'hFFFFF) begin
      gap <= gap + 20'h00001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence req_ack;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  wait_one_a: assert property (req_wait |=> req_ack)
    else $error("bus wait not one cycle");
  data_hold_a: assert property (req_ack ##0 avs_read |=> $stable(avs_readdata))
    else $error("read data changed early");
  start_pulse_a: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  slot_gap_a: assert property (conv_req.start && seen |-> gap >= 20'(MIN_SLOT))
    else $error("starts too close");
  seq_next_a: assert property (conv_req.start && seen && seq8 |-> conv_req.channel == last_ch + 3'h1)
    else $error("sequential order broken");
  prio_one_a: assert property (conv_req.start && seen && prio_hl && conv_req.channel != 3'h0
    && conv_req.channel != 3'h5 |-> last_ch == 3'h0)
    else $error("channel one not between");
  skip_group_a: assert property (conv_req.start && group_range_switch[7:4] == 4'hF |-> conv_req.channel <= bord)
    else $error("unused group scanned");
  status_ok_a: assert property (req_ack ##0 avs_read && run_led && avs_address[5:2] < 4'hC
    |-> avs_readdata[31:24] == STAT_NORMAL)
    else $error("status byte not normal");
endmodule : isac_checker

bind isac_top isac_checker #(.FAST_HL_SLOT(FAST_HL_SLOT), .PRIO_SLOT(PRIO_SLOT)) u_isac_checker (
  .clk(clk), .rst_n(rst_n), .group_range_switch(group_range_switch),
  .border_units_average_switch(border_units_average_switch), .scan_option_switch(scan_option_switch),
  .conv_req(conv_req), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .run_led(run_led));

/* File: test/isac_conv_model.sv */
// converter model: answers each start with ch*256+4*k, k counting per channel
// assumes the top's clock; lat sets the answer delay, mute drops answers
`timescale 1ns/1ns
module isac_conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // converter link
  input isac_pkg::isac_conv_req_t conv_req,
  output isac_pkg::isac_conv_rsp_t conv_rsp,
  // bench controls
  input wire logic ready_on,
  input wire logic mute,
  input wire logic [3:0] lat
);
  import isac_pkg::*;
  logic busy;
  logic [3:0] cnt;
  logic [7:0] k [8];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      conv_rsp <= '0;
      foreach (k[i]) k[i] <= 8'h00;
    end else begin
      conv_rsp.ready <= ready_on;
      conv_rsp.done <= 1'b0;
      // idle data is not held
      conv_rsp.data <= ~conv_rsp.data;
      if (conv_req.start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        if (!mute) begin
          conv_rsp.done <= 1'b1;
          conv_rsp.data <= {5'h00, conv_req.channel, 8'h00} + {6'h00, k[conv_req.channel], 2'h0};
          k[conv_req.channel] <= k[conv_req.channel] + 8'h01;
        end
      end
    end
  end
endmodule : isac_conv_model

/* File: test/isac_top_tb.sv */
// self-checking bench for the scan/average control top
// assumes the converter model beside it and short slot parameters
`timescale 1ns/1ns
module isac_top_tb;
  import isac_pkg::*;
  localparam int FHL = 20;
  localparam int FTC = 40;
  localparam int AHL = 30;
  localparam int ATC = 50;
  localparam int PS = 24;
  localparam int IW = 50;
  localparam int PT[13] = '{0, 1, 0, 2, 0, 3, 0, 4, 5, 0, 6, 0, 7};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] grp = 8'h55;
  logic [7:0] bsw = 8'h00;
  logic [5:0] ssw = 6'h00;
  isac_conv_req_t conv_req;
  isac_conv_rsp_t conv_rsp;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic wreq;
  logic run_led;
  logic rdy_on = 1'b1;
  logic mute = 1'b0;
  logic [3:0] lat = 4'h2;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int dn[8];
  logic [2:0] sq_ch[$];
  int sq_t[$];
  logic [31:0] d;

  always #20 clk = ~clk;

  isac_top #(.FAST_HL_SLOT(FHL), .FAST_TC_SLOT(FTC), .ACC_HL_SLOT(AHL), .ACC_TC_SLOT(ATC),
    .PRIO_SLOT(PS), .CONV_TIMEOUT(40), .INIT_WAIT(IW)) u_isac_top (
    .clk(clk), .rst_n(rst_n), .group_range_switch(grp), .border_units_average_switch(bsw),
    .scan_option_switch(ssw), .conv_req(conv_req), .conv_rsp(conv_rsp), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .run_led(run_led));
  isac_conv_model u_isac_conv_model (.clk(clk), .rst_n(rst_n), .conv_req(conv_req),
    .conv_rsp(conv_rsp), .ready_on(rdy_on), .mute(mute), .lat(lat));

  // logs every start and counts answers per channel
  always @(posedge clk) begin
    cyc++;
    if (rst_n && conv_req.start === 1'b1) begin
      sq_ch.push_back(conv_req.channel);
      sq_t.push_back(cyc);
    end
    if (conv_rsp.done === 1'b1) dn[conv_req.channel]++;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task bus(input logic [5:0] a, input logic w, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= wd;
    // waitrequest seen low at a rising edge ends the transfer
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task do_reset(input logic [7:0] g, input logic [7:0] b, input logic [5:0] s, input logic r);
    int n;
    n = 0;
    @(posedge clk);
    rst_n <= 1'b0;
    grp <= g;
    bsw <= b;
    ssw <= s;
    rdy_on <= r;
    mute <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    sq_ch.delete();
    sq_t.delete();
    foreach (dn[i]) dn[i] = 0;
    while (r && run_led !== 1'b1 && n < IW + 40) begin
      @(posedge clk);
      n++;
    end
  endtask : do_reset

  // order and spacing of the first n starts
  task chk_scan(input int base, input int cnt, input bit pr, input int slot, input int n);
    int w;
    int e;
    int g;
    w = 0;
    while (sq_ch.size() < n && w < n * slot + 300) begin
      @(posedge clk);
      w++;
    end
    chk(32'(sq_ch.size() >= n), 32'h00000001);
    for (int i = 0; i < n && i < sq_ch.size(); i++) begin
      e = pr ? PT[i % 13] : base + i % cnt;
      chk({29'h0, sq_ch[i]}, 32'(e));
      g = (i > 0) ? sq_t[i] - sq_t[i - 1] : slot;
      chk(32'(g >= slot && g <= slot + 1), 32'h00000001);
    end
  endtask : chk_scan

  task halt;
    bus(6'h30, 1'b1, 32'h00000000, d);
    repeat (40) @(posedge clk);
    bus(6'h30, 1'b0, 32'h00000000, d);
    chk(d, 32'h00000000);
  endtask : halt

  // mean of the last dep samples, ramping while the stack fills
  task chk_ch(input int ch, input int dep, input bit fh);
    int s;
    int lo;
    s = 0;
    lo = dn[ch] > dep ? dn[ch] - dep : 0;
    for (int k = lo; k < dn[ch]; k++) s += ch * 256 + 4 * k;
    s = s / dep;
    if (fh) s = s * 9 / 5 + 320;
    bus(6'(ch * 4), 1'b0, 32'h00000000, d);
    chk(d, {8'hC7, 8'h00, 16'(s)});
  endtask : chk_ch

  task t_seq;
    do_reset(8'h55, 8'h00, 6'h00, 1'b1);
    chk({31'h0, run_led}, 32'h00000001);
    chk_scan(0, 8, 1'b0, FHL, 17);
    chk({31'h0, conv_req.tc}, 32'h00000000);
    bus(6'h00, 1'b0, 32'h00000000, d);
    chk({24'h0, d[31:24]}, 32'h000000C7);
    bus(6'h28, 1'b0, 32'h00000000, d);
    chk(d, 32'hC7005500);
    bus(6'h2C, 1'b0, 32'h00000000, d);
    chk(d, 32'hC7000000);
    bus(6'h30, 1'b0, 32'h00000000, d);
    chk(d, 32'h00000001);
    bus(6'h34, 1'b0, 32'h00000000, d);
    chk(d, 32'h00000000);
  endtask : t_seq

  task t_prio;
    do_reset(8'h55, 8'h00, 6'h01, 1'b1);
    chk_scan(0, 8, 1'b1, PS, 27);
  endtask : t_prio

  task t_acc;
    do_reset(8'h55, 8'h00, 6'h3E, 1'b1);
    chk_scan(0, 8, 1'b0, AHL, 10);
  endtask : t_acc

  task t_skip;
    do_reset(8'hF5, 8'h04, 6'h00, 1'b1);
    chk_scan(0, 4, 1'b0, FHL, 9);
    do_reset(8'h5F, 8'h04, 6'h00, 1'b1);
    chk_scan(4, 4, 1'b0, FHL, 9);
  endtask : t_skip

  task t_avg;
    do_reset(8'h55, 8'hE4, 6'h00, 1'b1);
    repeat (1000) @(posedge clk);
    halt();
    for (int c = 0; c < 8; c++) chk_ch(c, c < 4 ? 4 : 1, 1'b0);
    lat <= 4'hA;
    do_reset(8'h55, 8'h14, 6'h00, 1'b1);
    repeat (2000) @(posedge clk);
    halt();
    for (int c = 0; c < 8; c++) chk_ch(c, c < 4 ? 8 : 32, 1'b0);
    lat <= 4'h2;
  endtask : t_avg

  task t_tc;
    do_reset(8'hFE, 8'h38, 6'h03, 1'b1);
    chk_scan(0, 8, 1'b0, ATC, 9);
    chk({31'h0, conv_req.tc}, 32'h00000001);
    halt();
    chk_ch(0, 1, 1'b0);
    do_reset(8'hFE, 8'h30, 6'h00, 1'b1);
    chk_scan(0, 8, 1'b0, FTC, 9);
    halt();
    chk_ch(7, 1, 1'b1);
  endtask : t_tc

  task t_fail;
    int n;
    n = 0;
    do_reset(8'h55, 8'h00, 6'h00, 1'b0);
    bus(6'h00, 1'b0, 32'h00000000, d);
    chk({24'h0, d[31:24]}, 32'h00000069);
    repeat (IW + 20) @(posedge clk);
    bus(6'h04, 1'b0, 32'h00000000, d);
    chk({24'h0, d[31:24]}, 32'h00000060);
    chk({31'h0, run_led}, 32'h00000000);
    do_reset(8'h55, 8'h00, 6'h00, 1'b1);
    mute <= 1'b1;
    while (run_led !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, run_led}, 32'h00000000);
    bus(6'h08, 1'b0, 32'h00000000, d);
    chk({24'h0, d[31:24]}, 32'h00000053);
  endtask : t_fail

  initial begin
    t_seq();
    t_prio();
    t_acc();
    t_skip();
    t_avg();
    t_tc();
    t_fail();
    stop_test();
  end

  // cuts a hang short
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : isac_top_tb
